// ==== rtl/ebrs_sequencer.v ====
// Ethernet boot request sequencer: setup, wait, request frame, boot frames
// How it works
// R01: Single-port variant boots only from port 0 with mode 1000b.
// R02: Mode 1001b boots port 0, forwards on port 1.
// R03: Mode 1010b boots port 1, forwards on port 0.
// R04: Switch control loaded with 0x000000E0 flow-control value.
// R05: Both port MAC source addresses get the fused MAC address.
// R06: Switch DMA transmit, receive and lookup engine enabled.
// R07: Lookup table cleared, then one entry with device MAC.
// R08: All ports forward; gigabit media interface on ports 0 and 1.
// R09: Boot port is link slave, other port master with autonegotiation.
// R10: Wait about 25 ms after switch setup before sending.
// R11: Init descriptors, then send request frame once, never again.
// R12: Then wait for boot frames indefinitely, then start application.
// R13: Frames on boot port not for us forward out other port.
// R14: Each transmit lane config loaded with 0x00000B21.
// R15: Each receive lane config loaded with 0x00089121.
// R16: Transceiver PLL left at power-on defaults.
// R17: Request header: broadcast, device MAC, type 0x0800.
// R18: IPv4 header fields fixed as listed, checksum A9A5.
// R19: UDP source port 68, destination port 9.
// R20: Host boot frames start 0x544B, opcode 0x01, sequence from 0.
// R21: Frames failing header checks dropped silently, next frame processed.
// R22: Wait is a cycle counter at the real clock rate.
// R23: Steps run in order: serdes, switch, wait, descriptors, send.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "ebrs_consts.vh"
module ebrs_sequencer #(
  parameter [31:0] WAIT_CYCLES = `EBRS_WAIT_CYC,
  parameter SINGLE_PORT = 0
) (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Straps and fuses
  input wire [3:0] boot_mode,
  input wire [47:0] fuse_mac,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Switch configuration outputs
  output reg [31:0] serdes_tx_lane_config,
  output reg [31:0] serdes_rx_lane_config,
  output reg [31:0] switch_control,
  output reg [47:0] port0_mac_source_address,
  output reg [47:0] port1_mac_source_address,
  output reg switch_dma_tx_en,
  output reg switch_dma_rx_en,
  output reg lookup_en,
  output reg lookup_clear,
  output reg lookup_wr,
  output reg [47:0] lookup_entry,
  output reg [2:0] port_forward_en,
  output reg [1:0] gmii_en,
  output reg [1:0] port_link_master,
  output reg [1:0] port_autoneg_en,
  output reg boot_port,
  output reg desc_init,
  // Request frame byte stream
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_last,
  input wire tx_ready,
  // Received boot-port byte stream
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_sof,
  input wire rx_eof,
  input wire rx_for_us,
  // Forwarding and handoff
  output reg fwd_frame,
  output reg fwd_port,
  output reg [7:0] bt_data,
  output reg bt_valid,
  output reg app_start,
  output reg mode_error
);
  localparam S_IDLE = 8'h01;
  localparam S_SERDES = 8'h02;
  localparam S_SWITCH = 8'h04;
  localparam S_LOOKUP = 8'h08;
  localparam S_WAIT = 8'h10;
  localparam S_DESC = 8'h20;
  localparam S_SEND = 8'h40;
  localparam S_BOOT = 8'h80;
  localparam [15:0] IP_TOTLEN = `EBRS_IP_TOTLEN;
  localparam [15:0] IP_ID = `EBRS_IP_ID;
  localparam [15:0] IP_CSUM = `EBRS_IP_CSUM;
  localparam [15:0] UDP_SRC = `EBRS_UDP_SRC;
  localparam [15:0] UDP_DST = `EBRS_UDP_DST;
  localparam [15:0] BT_MAGIC = `EBRS_BT_MAGIC;

  reg [7:0] state;
  reg [7:0] next_state;
  reg [31:0] wait_cnt;
  reg [5:0] tx_idx;
  reg [3:0] mode_q;
  reg [47:0] mac_q;
  reg sent;
  reg [3:0] hdr_idx;
  reg hdr_ok;
  reg [7:0] exp_seq;
  reg [7:0] seq_q;
  reg [15:0] frames_ok;
  reg [15:0] frames_bad;
  reg done_req;
  reg [3:0] mode_meta;
  reg [3:0] mode_mid;
  reg [3:0] mode_last;
  reg [3:0] mode_sync;
  reg [47:0] mac_meta;
  reg [47:0] mac_mid;
  reg [47:0] mac_last;
  reg [47:0] mac_sync;

  // Request frame byte lookup
  function [7:0] req_byte;
    input [5:0] i;
    input [47:0] mac;
    begin
      case (i)
        6'd0, 6'd1, 6'd2, 6'd3, 6'd4, 6'd5: req_byte = 8'hFF;
        6'd6: req_byte = mac[47:40];
        6'd7: req_byte = mac[39:32];
        6'd8: req_byte = mac[31:24];
        6'd9: req_byte = mac[23:16];
        6'd10: req_byte = mac[15:8];
        6'd11: req_byte = mac[7:0];
        6'd12: req_byte = `EBRS_ETH_TYPE_HI;
        6'd14: req_byte = `EBRS_IP_VERLEN;
        6'd16: req_byte = IP_TOTLEN[15:8];
        6'd17: req_byte = IP_TOTLEN[7:0];
        6'd18: req_byte = IP_ID[15:8];
        6'd19: req_byte = IP_ID[7:0];
        6'd22: req_byte = `EBRS_IP_TTL;
        6'd23: req_byte = `EBRS_IP_PROTO;
        6'd24: req_byte = IP_CSUM[15:8];
        6'd25: req_byte = IP_CSUM[7:0];
        6'd34: req_byte = UDP_SRC[15:8];
        6'd35: req_byte = UDP_SRC[7:0];
        6'd36: req_byte = UDP_DST[15:8];
        6'd37: req_byte = UDP_DST[7:0];
        default: req_byte = 8'h00;
      endcase
    end
  endfunction

  // Mode check for supported Ethernet codes
  function mode_valid;
    input [3:0] m;
    begin
      // R01 port0 only variant
      if (SINGLE_PORT != 0)
        mode_valid = (m == `EBRS_MODE_P0_ONLY);
      else
        mode_valid = (m == `EBRS_MODE_P0_ONLY) || (m == `EBRS_MODE_P0) || (m == `EBRS_MODE_P1);
    end
  endfunction

  // Strap and fuse synchronisers, new value once two stages agree
  always @(posedge core_clk) begin
    mode_meta <= boot_mode;
    mode_mid <= mode_meta;
    mode_last <= mode_mid;
    if (mode_mid == mode_last)
      mode_sync <= mode_last;
    mac_meta <= fuse_mac;
    mac_mid <= mac_meta;
    mac_last <= mac_mid;
    if (mac_mid == mac_last)
      mac_sync <= mac_last;
  end

  wire tx_fire = tx_valid && tx_ready;
  wire wait_done = (wait_cnt >= WAIT_CYCLES - 32'h00000001);

  // R23 ordered step sequence
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: next_state = mode_valid(mode_q) ? S_SERDES : S_IDLE;
      S_SERDES: next_state = S_SWITCH;
      S_SWITCH: next_state = S_LOOKUP;
      S_LOOKUP: next_state = S_WAIT;
      S_WAIT: next_state = wait_done ? S_DESC : S_WAIT;
      S_DESC: next_state = sent ? S_BOOT : S_SEND;
      S_SEND: next_state = (tx_fire && tx_last) ? S_BOOT : S_SEND;
      S_BOOT: next_state = S_BOOT;
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      state <= S_IDLE;
      mode_q <= 4'h0;
      mac_q <= 48'h000000000000;
      wait_cnt <= 32'h00000000;
      tx_idx <= 6'h00;
      sent <= 1'b0;
      serdes_tx_lane_config <= 32'h00000000;
      serdes_rx_lane_config <= 32'h00000000;
      switch_control <= 32'h00000000;
      port0_mac_source_address <= 48'h000000000000;
      port1_mac_source_address <= 48'h000000000000;
      switch_dma_tx_en <= 1'b0;
      switch_dma_rx_en <= 1'b0;
      lookup_en <= 1'b0;
      lookup_clear <= 1'b0;
      lookup_wr <= 1'b0;
      lookup_entry <= 48'h000000000000;
      port_forward_en <= 3'h0;
      gmii_en <= 2'h0;
      port_link_master <= 2'h0;
      port_autoneg_en <= 2'h0;
      boot_port <= 1'b0;
      desc_init <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      mode_error <= 1'b0;
    end else begin
      state <= next_state;
      lookup_clear <= 1'b0;
      lookup_wr <= 1'b0;
      desc_init <= 1'b0;
      if (state == S_IDLE) begin
        // R05 mac and mode caught after reset release
        mode_q <= mode_sync;
        mac_q <= mac_sync;
        mode_error <= (mode_q != 4'h0) && !mode_valid(mode_q);
      end
      case (state)
        S_SERDES: begin
          // R14 transmit lane value
          serdes_tx_lane_config <= `EBRS_TX_LANE_CFG;
          // R15 receive lane value
          serdes_rx_lane_config <= `EBRS_RX_LANE_CFG;
          // R16 pll untouched
        end
        S_SWITCH: begin
          // R04 switch flow control
          switch_control <= `EBRS_SWITCH_CTRL;
          // R05 source addresses
          port0_mac_source_address <= mac_q;
          port1_mac_source_address <= mac_q;
          // R06 dma and lookup enable
          switch_dma_tx_en <= 1'b1;
          switch_dma_rx_en <= 1'b1;
          lookup_en <= 1'b1;
          // R07 clear table first
          lookup_clear <= 1'b1;
          // R08 forwarding and gmii
          port_forward_en <= 3'h7;
          gmii_en <= 2'h3;
          // R02 R03 boot port pick
          boot_port <= (mode_q == `EBRS_MODE_P1);
          // R09 slave and master roles
          port_link_master <= (mode_q == `EBRS_MODE_P1) ? 2'h1 : 2'h2;
          port_autoneg_en <= (mode_q == `EBRS_MODE_P1) ? 2'h1 : 2'h2;
        end
        S_LOOKUP: begin
          // R07 single entry insert
          lookup_wr <= 1'b1;
          lookup_entry <= mac_q;
        end
        S_WAIT: begin
          // R10 R22 autonegotiation wait counter
          wait_cnt <= wait_cnt + 32'h00000001;
        end
        S_DESC: begin
          // R11 descriptor init
          desc_init <= 1'b1;
          tx_idx <= 6'h00;
        end
        S_SEND: begin
          // R17 R18 R19 request frame bytes
          if (!tx_valid || tx_fire) begin
            if (tx_fire && tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              // R11 sent once only
              sent <= 1'b1;
            end else begin
              tx_data <= req_byte(tx_idx, mac_q);
              tx_valid <= 1'b1;
              tx_last <= (tx_idx == `EBRS_REQ_LEN - 1);
              tx_idx <= tx_idx + 6'h01;
            end
          end
        end
        default: begin
          tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // R12 boot frame reception
  always @(posedge core_clk) begin
    if (srst) begin
      hdr_idx <= 4'h0;
      hdr_ok <= 1'b0;
      exp_seq <= 8'h00;
      seq_q <= 8'h00;
      frames_ok <= 16'h0000;
      frames_bad <= 16'h0000;
      fwd_frame <= 1'b0;
      fwd_port <= 1'b0;
      bt_data <= 8'h00;
      bt_valid <= 1'b0;
      app_start <= 1'b0;
    end else begin
      bt_valid <= 1'b0;
      if (state == S_BOOT && rx_valid && !app_start) begin
        if (rx_sof) begin
          // R13 forward frames not for us
          fwd_frame <= !rx_for_us;
          fwd_port <= ~boot_port;
          hdr_idx <= 4'h1;
          hdr_ok <= rx_for_us && (rx_data == BT_MAGIC[15:8]);
        end else if (!fwd_frame) begin
          // R20 R21 header check, silent drop
          case (hdr_idx)
            4'h1: hdr_ok <= hdr_ok && (rx_data == BT_MAGIC[7:0]);
            4'h2: hdr_ok <= hdr_ok && (rx_data == `EBRS_BT_OPCODE);
            4'h3: begin
              hdr_ok <= hdr_ok && (rx_data == exp_seq);
              seq_q <= rx_data;
            end
            default: begin
              bt_data <= rx_data;
              bt_valid <= hdr_ok;
            end
          endcase
          if (hdr_idx != 4'h4)
            hdr_idx <= hdr_idx + 4'h1;
        end
        if (rx_eof && !rx_sof) begin
          if (!fwd_frame && hdr_ok && hdr_idx == 4'h4) begin
            frames_ok <= frames_ok + 16'h0001;
            exp_seq <= seq_q + 8'h01;
          end else if (!fwd_frame) begin
            frames_bad <= frames_bad + 16'h0001;
          end
          fwd_frame <= 1'b0;
        end
      end
      // R12 handoff when software signals table complete
      if (done_req && state == S_BOOT)
        app_start <= 1'b1;
    end
  end

  // APB registers
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == `EBRS_APB_STATUS || paddr == `EBRS_APB_CTRL ||
    paddr == `EBRS_APB_FRAMES);

  always @(posedge core_clk) begin
    if (srst)
      done_req <= 1'b0;
    else if (psel && penable && pwrite && paddr == `EBRS_APB_CTRL)
      done_req <= pwdata[0];
  end

  always @(posedge core_clk) begin
    if (srst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `EBRS_APB_STATUS: prdata <= {12'h000, mode_q, exp_seq, state};
        `EBRS_APB_CTRL: prdata <= {27'h0, mode_error, app_start, boot_port, sent, done_req};
        `EBRS_APB_FRAMES: prdata <= {frames_bad, frames_ok};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // ebrs_sequencer

// ==== rtl/ebrs_consts.vh ====
// Constants for the Ethernet boot request sequencer
`ifndef EBRS_CONSTS_VH
`define EBRS_CONSTS_VH
`define EBRS_MODE_P0_ONLY 4'h8
`define EBRS_MODE_P0 4'h9
`define EBRS_MODE_P1 4'hA
`define EBRS_TX_LANE_CFG 32'h00000B21
`define EBRS_RX_LANE_CFG 32'h00089121
`define EBRS_SWITCH_CTRL 32'h000000E0
`define EBRS_WAIT_MS 25
`define EBRS_CLK_MHZ 125
`define EBRS_WAIT_CYC (`EBRS_WAIT_MS * 1000 * `EBRS_CLK_MHZ)
`define EBRS_REQ_LEN 38
`define EBRS_ETH_TYPE_HI 8'h08
`define EBRS_IP_VERLEN 8'h45
`define EBRS_IP_TOTLEN 16'h0148
`define EBRS_IP_ID 16'h0001
`define EBRS_IP_TTL 8'h10
`define EBRS_IP_PROTO 8'h11
`define EBRS_IP_CSUM 16'hA9A5
`define EBRS_UDP_SRC 16'h0044
`define EBRS_UDP_DST 16'h0009
`define EBRS_BT_MAGIC 16'h544B
`define EBRS_BT_OPCODE 8'h01
`define EBRS_APB_STATUS 12'h000
`define EBRS_APB_CTRL 12'h004
`define EBRS_APB_FRAMES 12'h008
`endif

// ==== test/ebrs_props.sv ====
// Checker for the boot request sequencer ports
`timescale 1ns/1ps
`include "ebrs_consts.vh"
module ebrs_props (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Observed design signals
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire tx_last,
  input wire lookup_clear,
  input wire lookup_wr,
  input wire desc_init,
  input wire [31:0] switch_control,
  input wire [31:0] serdes_tx_lane_config,
  input wire app_start,
  input wire bt_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx byte changed while stalled");
  no_resend_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid [*8])
    else $error("request sent again");
  lkup_seq_a: assert property (lookup_clear |=> lookup_wr && !lookup_clear)
    else $error("lookup write not after clear");
  wait_gap_a: assert property (lookup_wr |=> (!desc_init && !tx_valid) [*8])
    else $error("send before negotiation wait");
  desc_send_a: assert property (desc_init |-> ##[1:20] tx_valid)
    else $error("no send after descriptor init");
  cfg_val_a: assert property (desc_init |-> switch_control == `EBRS_SWITCH_CTRL && serdes_tx_lane_config == `EBRS_TX_LANE_CFG)
    else $error("config value wrong at send");
  bcast_a: assert property ($rose(tx_valid) |-> tx_data == 8'hFF)
    else $error("first byte not broadcast");
  app_stick_a: assert property (app_start |=> app_start)
    else $error("app start dropped");
  cover property (desc_init);
  cover property (tx_valid && tx_ready && tx_last);
  cover property (bt_valid);
endmodule // ebrs_props
bind ebrs_sequencer ebrs_props p (.core_clk, .srst, .tx_data, .tx_valid, .tx_ready, .tx_last, .lookup_clear,
  .lookup_wr, .desc_init, .switch_control, .serdes_tx_lane_config, .app_start, .bt_valid);

// ==== test/ebrs_host.sv ====
// Boot host model: stalling frame sink and boot frame source
`timescale 1ns/1ps
module ebrs_host (
  // Clock
  input wire core_clk,
  // Request stream
  input wire [7:0] tx_data,
  input wire tx_valid,
  output logic tx_ready = 0,
  // Boot frame stream
  output logic [7:0] rx_data = 8'h00,
  output logic rx_valid = 0,
  output logic rx_sof = 0,
  output logic rx_eof = 0,
  output logic rx_for_us = 0
);
  logic [7:0] got [0:37];
  int n = 0;
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready && n < 38) begin
      got[n] <= tx_data;
      n <= n + 1;
    end
    tx_ready <= ~tx_ready;
  end
  task automatic send(input logic [7:0] b0, input logic [7:0] sq, input logic us);
    logic [7:0] f [0:7];
    f = '{b0, 8'h4B, 8'h01, sq, 8'h11, 8'h22, 8'h33, 8'h44};
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      rx_valid <= 1;
      rx_data <= f[i];
      rx_sof <= (i == 0);
      rx_eof <= (i == 7);
      rx_for_us <= (i == 0) && us;
    end
    @(posedge core_clk);
    rx_valid <= 0;
    rx_eof <= 0;
    rx_data <= ~f[7];
  endtask
endmodule // ebrs_host

// ==== test/ethernet_boot_request_sequencer_tb.sv ====
// Testbench for the boot request sequencer
`timescale 1ns/1ps
module ethernet_boot_request_sequencer_tb;
  localparam logic [47:0] MAC = 48'h0A1B2C3D4E5F;
  localparam logic [207:0] TAIL = 208'h0800_4500_0148_0001_0000_1011_A9A5_0000_0000_0000_0000_0044_0009;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [3:0] boot_mode = 4'h9;
  logic [47:0] fuse_mac = MAC;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, serdes_tx_lane_config, serdes_rx_lane_config, switch_control, rd;
  logic [47:0] port0_mac_source_address, port1_mac_source_address, lookup_entry;
  logic [7:0] tx_data, rx_data, bt_data, bt_last;
  logic [2:0] port_forward_en;
  logic [1:0] gmii_en, port_link_master, port_autoneg_en, lm;
  logic pready, pslverr, switch_dma_tx_en, switch_dma_rx_en, lookup_en, lookup_clear, lookup_wr, boot_port, er;
  logic desc_init, tx_valid, tx_last, tx_ready, rx_valid, rx_sof, rx_eof, rx_for_us;
  logic fwd_frame, fwd_port, bt_valid, app_start, mode_error, sp_err, fwd_seen = 0;
  int n_errors = 0, compares = 0, nbt = 0;
  // Row: mode, single-port error, error, boot port
  logic [7:0] rows [0:3] = '{8'h36, 8'h94, 8'h80, 8'hA5};
  always #4 core_clk = ~core_clk;
  ebrs_sequencer #(.WAIT_CYCLES(20), .SINGLE_PORT(0)) uut (.core_clk, .srst, .boot_mode, .fuse_mac, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .serdes_tx_lane_config,
    .serdes_rx_lane_config, .switch_control, .port0_mac_source_address, .port1_mac_source_address,
    .switch_dma_tx_en, .switch_dma_rx_en, .lookup_en, .lookup_clear, .lookup_wr, .lookup_entry,
    .port_forward_en, .gmii_en, .port_link_master, .port_autoneg_en, .boot_port, .desc_init, .tx_data,
    .tx_valid, .tx_last, .tx_ready, .rx_data, .rx_valid, .rx_sof, .rx_eof, .rx_for_us, .fwd_frame,
    .fwd_port, .bt_data, .bt_valid, .app_start, .mode_error);
  ebrs_host host (.core_clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_sof, .rx_eof, .rx_for_us);
  ebrs_sequencer #(.WAIT_CYCLES(20), .SINGLE_PORT(1)) uut_single (.core_clk, .srst, .boot_mode, .fuse_mac,
    .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(12'h000), .pwdata(32'h00000000), .pready(), .prdata(),
    .pslverr(), .serdes_tx_lane_config(), .serdes_rx_lane_config(), .switch_control(),
    .port0_mac_source_address(), .port1_mac_source_address(), .switch_dma_tx_en(), .switch_dma_rx_en(),
    .lookup_en(), .lookup_clear(), .lookup_wr(), .lookup_entry(), .port_forward_en(), .gmii_en(),
    .port_link_master(), .port_autoneg_en(), .boot_port(), .desc_init(), .tx_data(), .tx_valid(), .tx_last(),
    .tx_ready(1'b1), .rx_data(8'h00), .rx_valid(1'b0), .rx_sof(1'b0), .rx_eof(1'b0), .rx_for_us(1'b0),
    .fwd_frame(), .fwd_port(), .bt_data(), .bt_valid(), .app_start(), .mode_error(sp_err));
  always @(posedge core_clk) begin
    if (bt_valid === 1'b1) begin
      nbt <= nbt + 1;
      bt_last <= bt_data;
    end
    if (fwd_frame === 1'b1) fwd_seen <= 1;
  end
  function automatic logic [7:0] fb(int i);
    return i < 6 ? 8'hFF : i < 12 ? MAC[8*(11-i)+:8] : TAIL[8*(37-i)+:8];
  endfunction
  task final_report;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    k = 0;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    if (k >= 50) begin n_errors++; final_report; end
  endtask
  initial begin
    for (int r = 0; r < 4; r++) begin
      boot_mode <= rows[r][7:4];
      srst <= 1;
      host.n = 0;
      repeat (10) @(posedge core_clk);
      srst <= 0;
      lm = rows[r][0] ? 2'b01 : 2'b10;
      if (rows[r][1]) begin
        repeat (4) @(posedge core_clk);
        chk("mode_error", 1, mode_error);
      end else begin
        for (int k = 0; k < 500 && host.n < 38; k++) @(posedge core_clk);
        if (host.n < 38) begin n_errors++; final_report; end
        for (int i = 0; i < 38; i++) chk("tx_byte", fb(i), host.got[i]);
        chk("boot_port", rows[r][0], boot_port);
        chk("link", {lm, lm}, {port_link_master, port_autoneg_en});
        chk("fwd_gmii", 5'h1F, {port_forward_en, gmii_en});
        chk("mac0", MAC, port0_mac_source_address);
        chk("mac1", MAC, port1_mac_source_address);
        chk("serdes", {32'h00000B21, 32'h00089121}, {serdes_tx_lane_config, serdes_rx_lane_config});
        chk("sw_ctrl", 32'h000000E0, switch_control);
        chk("dma_ale", 3'h7, {switch_dma_tx_en, switch_dma_rx_en, lookup_en});
        chk("lookup_entry", MAC, lookup_entry);
      end
      chk("single_port", rows[r][2], sp_err);
    end
    host.send(8'h54, 8'h00, 1);
    host.send(8'h00, 8'h01, 1);
    repeat (4) @(posedge core_clk);
    chk("bt_bytes", 4, nbt);
    host.send(8'h54, 8'h01, 1);
    host.send(8'h54, 8'h00, 0);
    repeat (4) @(posedge core_clk);
    chk("bt_next", 8, nbt);
    chk("fwd", 2'b10, {fwd_seen, fwd_port});
    chk("bt_data", 8'h44, bt_last);
    apb(1, 12'h004, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("app_start", 1, app_start);
    apb(0, 12'h004, 32'h0);
    chk("ctrl", 32'h0000000F, rd);
    apb(0, 12'h008, 32'h0);
    chk("frames", 32'h00010002, rd);
    apb(0, 12'hFFC, 32'h0);
    chk("unmapped", {1'b1, 32'h0}, {er, rd});
    final_report;
  end
endmodule // ethernet_boot_request_sequencer_tb
